/* design/actuator_config_registers.sv */
// What this block does
// - Writable 7-bit bus base address, resets 0x4A.
// - 15-bit period: high eight bits, low seven.
// - Software encodes period from resonant frequency.
// - Period resets to high 0x21, low 0x4F.
// - Nominal rating sets full scale when accelerating.
// - Accelerating clamps overdrive to absolute rating, 0x78.
// - Not accelerating: absolute rating sets full scale.
// - 5-bit current code, resets to 0x17.
// - 16-bit scale factor from two byte registers.
// - Scale drives voltage level; resets 0x01, 0x0D.
// - Impedance high byte is read-only status.
// - Impedance low two bits at next offset.
// - Freeze bit stops automatic scale updates.
// - Single acceleration enable bit selects reference.
//
// The strobed register port was chosen for this implementation.
`timescale 1ns/1ns
`default_nettype none

module actuator_config_registers (
   // Clock and reset.
   input  wire logic                CLK,
   input  wire logic                RST,
   // Register link from the controller.
   actuator_cfg_if.device           bus,
   // Drive loop controls.
   input  wire logic                ACCEL_EN,
   input  wire logic                SCALE_UPDATE_FREEZE,
   // Automatic scale factor update.
   input  wire logic                SCALE_UPD,
   input  wire logic [15:0]         SCALE_NEW,
   // Impedance measurement result.
   input  wire logic                IMP_UPD,
   input  wire logic [7:0]          IMP_HI_IN,
   input  wire logic [1:0]          IMP_LO_IN,
   // Configuration toward the drive loop.
   output logic      [6:0]          BASE_ADDR,
   output logic      [14:0]         RESONANT_PERIOD_VALUE,
   output logic      [7:0]          FULL_SCALE,
   output logic      [7:0]          OVERDRIVE_LIMIT,
   output logic                     OVERDRIVE_CLAMP_EN,
   output logic      [4:0]          CURRENT_LIMIT_CODE,
   output logic      [15:0]         DRIVE_SCALE_VALUE
);

   logic [6:0]  base_ff;
   logic [7:0]  resonant_period_hi_byte_ff;
   logic [6:0]  resonant_period_lo_bits_ff;
   logic [7:0]  nominal_ff;
   logic [7:0]  absolute_ff;
   logic [4:0]  current_limit_code_ff;
   logic [7:0]  drive_scale_hi_byte_ff;
   logic [7:0]  drive_scale_lo_byte_ff;
   logic [7:0]  imp_hi_ff;
   logic [1:0]  imp_lo_ff;
   logic [7:0]  rdata_ff;
   logic [7:0]  nxt_rdata;
   logic [7:0]  full_scale_ff;
   logic [7:0]  overdrive_ff;
   logic        clamp_en_ff;

   // Bus base address; the top bit of a write is dropped, so it always reads zero.
   always_ff @(posedge CLK) begin
      if (RST) begin
         base_ff <= actuator_cfg_pkg::RST_BUS_ADDRESS_BASE;
      end else if (bus.wr && bus.addr == actuator_cfg_pkg::OFS_BUS_ADDRESS_BASE) begin
         base_ff <= bus.wdata[actuator_cfg_pkg::BASE_W-1:0];
      end
   end

   // Resonant period high byte.
   always_ff @(posedge CLK) begin
      if (RST) begin
         resonant_period_hi_byte_ff <= actuator_cfg_pkg::RST_RESONANT_PERIOD_HIGH;
      end else if (bus.wr && bus.addr == actuator_cfg_pkg::OFS_RESONANT_PERIOD_HIGH) begin
         resonant_period_hi_byte_ff <= bus.wdata;
      end
   end

   // Resonant period low bits; each half updates alone, so software should write both
   // halves back to back, and even then the drive loop sees a torn period for one cycle.
   always_ff @(posedge CLK) begin
      if (RST) begin
         resonant_period_lo_bits_ff <= actuator_cfg_pkg::RST_RESONANT_PERIOD_LOW;
      end else if (bus.wr && bus.addr == actuator_cfg_pkg::OFS_RESONANT_PERIOD_LOW) begin
         resonant_period_lo_bits_ff <= bus.wdata[actuator_cfg_pkg::PER_LO_W-1:0];
      end
   end

   // Nominal voltage rating.
   always_ff @(posedge CLK) begin
      if (RST) begin
         nominal_ff <= actuator_cfg_pkg::RST_NOMINAL_VOLTAGE_RATING;
      end else if (bus.wr && bus.addr == actuator_cfg_pkg::OFS_NOMINAL_VOLTAGE_RATING) begin
         nominal_ff <= bus.wdata;
      end
   end

   // Absolute voltage rating.
   always_ff @(posedge CLK) begin
      if (RST) begin
         absolute_ff <= actuator_cfg_pkg::RST_ABSOLUTE_VOLTAGE_RATING;
      end else if (bus.wr && bus.addr == actuator_cfg_pkg::OFS_ABSOLUTE_VOLTAGE_RATING) begin
         absolute_ff <= bus.wdata;
      end
   end

   // Current limit code; the three upper bits of a write are dropped.
   always_ff @(posedge CLK) begin
      if (RST) begin
         current_limit_code_ff <= actuator_cfg_pkg::RST_MAX_CURRENT_RATING;
      end else if (bus.wr && bus.addr == actuator_cfg_pkg::OFS_MAX_CURRENT_RATING) begin
         current_limit_code_ff <= bus.wdata[actuator_cfg_pkg::CUR_W-1:0];
      end
   end

   // Scale factor: a software write wins over an automatic update in the same cycle,
   // because software is the only way to recover from a bad calibration.
   always_ff @(posedge CLK) begin
      if (RST) begin
         drive_scale_hi_byte_ff <= actuator_cfg_pkg::RST_DRIVE_SCALE_HIGH;
         drive_scale_lo_byte_ff <= actuator_cfg_pkg::RST_DRIVE_SCALE_LOW;
      end else if (bus.wr && bus.addr == actuator_cfg_pkg::OFS_DRIVE_SCALE_HIGH) begin
         drive_scale_hi_byte_ff <= bus.wdata;
      end else if (bus.wr && bus.addr == actuator_cfg_pkg::OFS_DRIVE_SCALE_LOW) begin
         drive_scale_lo_byte_ff <= bus.wdata;
      end else if (SCALE_UPD && !SCALE_UPDATE_FREEZE) begin
         drive_scale_hi_byte_ff <= SCALE_NEW[15:8];
         drive_scale_lo_byte_ff <= SCALE_NEW[7:0];
      end
   end

   // Measured impedance is loaded only by the measurement, never by software.
   // A zero value means that no measurement has been taken since reset.
   always_ff @(posedge CLK) begin
      if (RST) begin
         imp_hi_ff <= actuator_cfg_pkg::RST_IMPEDANCE_HIGH;
         imp_lo_ff <= actuator_cfg_pkg::RST_IMPEDANCE_LOW;
      end else if (IMP_UPD) begin
         imp_hi_ff <= IMP_HI_IN;
         imp_lo_ff <= IMP_LO_IN;
      end
   end

   // Read decode; unmapped offsets and unused upper bits read zero.
   always_comb begin
      nxt_rdata = 8'h00;
      if (bus.addr == actuator_cfg_pkg::OFS_BUS_ADDRESS_BASE) begin
         nxt_rdata = {1'b0, base_ff};
      end else if (bus.addr == actuator_cfg_pkg::OFS_RESONANT_PERIOD_HIGH) begin
         nxt_rdata = resonant_period_hi_byte_ff;
      end else if (bus.addr == actuator_cfg_pkg::OFS_RESONANT_PERIOD_LOW) begin
         nxt_rdata = {1'b0, resonant_period_lo_bits_ff};
      end else if (bus.addr == actuator_cfg_pkg::OFS_NOMINAL_VOLTAGE_RATING) begin
         nxt_rdata = nominal_ff;
      end else if (bus.addr == actuator_cfg_pkg::OFS_ABSOLUTE_VOLTAGE_RATING) begin
         nxt_rdata = absolute_ff;
      end else if (bus.addr == actuator_cfg_pkg::OFS_MAX_CURRENT_RATING) begin
         nxt_rdata = {3'h0, current_limit_code_ff};
      end else if (bus.addr == actuator_cfg_pkg::OFS_DRIVE_SCALE_HIGH) begin
         nxt_rdata = drive_scale_hi_byte_ff;
      end else if (bus.addr == actuator_cfg_pkg::OFS_DRIVE_SCALE_LOW) begin
         nxt_rdata = drive_scale_lo_byte_ff;
      end else if (bus.addr == actuator_cfg_pkg::OFS_MEASURED_IMPEDANCE_HIGH) begin
         nxt_rdata = imp_hi_ff;
      end else if (bus.addr == actuator_cfg_pkg::OFS_MEASURED_IMPEDANCE_LOW) begin
         nxt_rdata = {6'h00, imp_lo_ff};
      end
   end

   // Read data is captured on the strobe and held until the next read.
   always_ff @(posedge CLK) begin
      if (RST) begin
         rdata_ff <= 8'h00;
      end else if (bus.rd) begin
         rdata_ff <= nxt_rdata;
      end
   end

   // The answer stands until the next read strobe, so the master may take it late.
   assign bus.rdata = rdata_ff;

   // Full-scale reference of unsigned waveform data follows the acceleration enable.
   always_ff @(posedge CLK) begin
      if (RST) begin
         full_scale_ff <= actuator_cfg_pkg::RST_NOMINAL_VOLTAGE_RATING;
      end else begin
         full_scale_ff <= ACCEL_EN ? nominal_ff : absolute_ff;
      end
   end

   // Overdrive clamp; limit and enable are registered together so they move as one.
   always_ff @(posedge CLK) begin
      if (RST) begin
         overdrive_ff  <= actuator_cfg_pkg::RST_ABSOLUTE_VOLTAGE_RATING;
         clamp_en_ff   <= 1'b0;
      end else begin
         overdrive_ff  <= absolute_ff;
         clamp_en_ff   <= ACCEL_EN;
      end
   end

   // Drive-loop views come straight from the register flops.
   assign BASE_ADDR             = base_ff;
   assign RESONANT_PERIOD_VALUE = {resonant_period_hi_byte_ff, resonant_period_lo_bits_ff};
   assign FULL_SCALE            = full_scale_ff;
   assign OVERDRIVE_LIMIT       = overdrive_ff;
   assign OVERDRIVE_CLAMP_EN    = clamp_en_ff;
   assign CURRENT_LIMIT_CODE    = current_limit_code_ff;
   assign DRIVE_SCALE_VALUE     = {drive_scale_hi_byte_ff, drive_scale_lo_byte_ff};

endmodule : actuator_config_registers

`default_nettype wire

/* design/actuator_cfg_pkg.sv */
package actuator_cfg_pkg;

   // Link geometry.
   localparam int ADDR_W = 8;
   localparam int DATA_W = 8;

   // Device register offsets.
   localparam logic [7:0] OFS_BUS_ADDRESS_BASE       = 8'h09;
   localparam logic [7:0] OFS_RESONANT_PERIOD_HIGH   = 8'h0a;
   localparam logic [7:0] OFS_RESONANT_PERIOD_LOW    = 8'h0b;
   localparam logic [7:0] OFS_NOMINAL_VOLTAGE_RATING = 8'h0c;
   localparam logic [7:0] OFS_ABSOLUTE_VOLTAGE_RATING = 8'h0d;
   localparam logic [7:0] OFS_MAX_CURRENT_RATING     = 8'h0e;
   localparam logic [7:0] OFS_DRIVE_SCALE_HIGH       = 8'h0f;
   localparam logic [7:0] OFS_DRIVE_SCALE_LOW        = 8'h10;
   localparam logic [7:0] OFS_MEASURED_IMPEDANCE_HIGH = 8'h11;
   localparam logic [7:0] OFS_MEASURED_IMPEDANCE_LOW = 8'h12;

   // Device field widths.
   localparam int BASE_W   = 7;
   localparam int PER_LO_W = 7;
   localparam int PERIOD_W = 15;
   localparam int CUR_W    = 5;
   localparam int SCALE_W  = 16;
   localparam int IMP_LO_W = 2;

   // Device reset values.
   localparam logic [6:0] RST_BUS_ADDRESS_BASE       = 7'h4a;
   localparam logic [7:0] RST_RESONANT_PERIOD_HIGH   = 8'h21;
   localparam logic [6:0] RST_RESONANT_PERIOD_LOW    = 7'h4f;
   localparam logic [7:0] RST_NOMINAL_VOLTAGE_RATING = 8'h5a;
   localparam logic [7:0] RST_ABSOLUTE_VOLTAGE_RATING = 8'h78;
   localparam logic [4:0] RST_MAX_CURRENT_RATING     = 5'h17;
   localparam logic [7:0] RST_DRIVE_SCALE_HIGH       = 8'h01;
   localparam logic [7:0] RST_DRIVE_SCALE_LOW        = 8'h0d;
   localparam logic [7:0] RST_IMPEDANCE_HIGH         = 8'h00;
   localparam logic [1:0] RST_IMPEDANCE_LOW          = 2'h0;

   // Controller register offsets.
   localparam logic [7:0] OFS_CTL_TARGET = 8'h00;
   localparam logic [7:0] OFS_CTL_WDATA  = 8'h01;
   localparam logic [7:0] OFS_CTL_CMD    = 8'h02;
   localparam logic [7:0] OFS_CTL_RDATA  = 8'h03;
   localparam logic [7:0] OFS_CTL_STATUS = 8'h04;
   localparam logic [7:0] OFS_CTL_WIDE_LO = 8'h05;
   localparam logic [7:0] OFS_CTL_WIDE_HI = 8'h06;

   // Controller command and status bits.
   localparam int CMD_WRITE  = 0;
   localparam int CMD_READ   = 1;
   localparam int CMD_PERIOD = 2;
   localparam int CMD_SCALE  = 3;
   localparam int STA_BUSY   = 0;
   localparam int STA_DONE   = 1;

endpackage : actuator_cfg_pkg

/* design/actuator_cfg_if.sv */
`timescale 1ns/1ns
`default_nettype none

interface actuator_cfg_if;
   // Register access from controller to device.
   logic [7:0] addr;
   logic [7:0] wdata;
   logic       wr;
   logic       rd;
   // Read answer, valid the cycle after rd.
   logic [7:0] rdata;

   modport device (input addr, input wdata, input wr, input rd, output rdata);
   modport host   (output addr, output wdata, output wr, output rd, input rdata);
endinterface : actuator_cfg_if

`default_nettype wire

/* design/actuator_cfg_host.sv */
`timescale 1ns/1ns
`default_nettype none

module actuator_cfg_host (
   // Clock and reset.
   input  wire logic       CLK,
   input  wire logic       RST,
   // Software command port.
   input  wire logic [7:0] ADDR,
   input  wire logic [7:0] WDATA,
   input  wire logic       WR,
   input  wire logic       RD,
   output logic      [7:0] RDATA,
   // Register link toward the device.
   actuator_cfg_if.host    bus
);

   typedef enum {S_IDLE, S_SINGLE_WR, S_READ, S_READ_WAIT, S_PAIR_HI, S_PAIR_LO} state_e;

   state_e      state_ff;
   logic [7:0]  target_ff;
   logic [7:0]  wdata_ff;
   logic [15:0] wide_ff;
   logic        is_scale_ff;
   logic [7:0]  last_rdata_ff;
   logic        done_ff;
   logic [7:0]  rdata_ff;
   logic [7:0]  bus_addr_ff;
   logic [7:0]  bus_wdata_ff;
   logic        bus_wr_ff;
   logic        bus_rd_ff;
   logic        cmd_wr;
   logic        busy;
   logic        finish;

   assign cmd_wr = WR && ADDR == actuator_cfg_pkg::OFS_CTL_CMD;
   assign busy   = state_ff != S_IDLE;
   assign finish = state_ff == S_SINGLE_WR || state_ff == S_READ_WAIT || state_ff == S_PAIR_LO;

   // Software-visible operands; ignored while a transfer runs so it cannot be torn.
   always_ff @(posedge CLK) begin
      if (RST) begin
         target_ff <= 8'h00;
         wdata_ff  <= 8'h00;
         wide_ff   <= 16'h0000;
      end else if (WR && !busy) begin
         if (ADDR == actuator_cfg_pkg::OFS_CTL_TARGET) begin
            target_ff <= WDATA;
         end else if (ADDR == actuator_cfg_pkg::OFS_CTL_WDATA) begin
            wdata_ff <= WDATA;
         end else if (ADDR == actuator_cfg_pkg::OFS_CTL_WIDE_LO) begin
            wide_ff[7:0] <= WDATA;
         end else if (ADDR == actuator_cfg_pkg::OFS_CTL_WIDE_HI) begin
            wide_ff[15:8] <= WDATA;
         end
      end
   end

   // Transfer sequencer; the lowest set command bit wins, and commands while busy drop.
   always_ff @(posedge CLK) begin
      if (RST) begin
         state_ff     <= S_IDLE;
         is_scale_ff  <= 1'b0;
         bus_addr_ff  <= 8'h00;
         bus_wdata_ff <= 8'h00;
         bus_wr_ff    <= 1'b0;
         bus_rd_ff    <= 1'b0;
      end else begin
         bus_wr_ff <= 1'b0;
         bus_rd_ff <= 1'b0;
         case (state_ff)
            S_IDLE: begin
               if (cmd_wr && WDATA[actuator_cfg_pkg::CMD_WRITE]) begin
                  bus_addr_ff  <= target_ff;
                  bus_wdata_ff <= wdata_ff;
                  bus_wr_ff    <= 1'b1;
                  state_ff     <= S_SINGLE_WR;
               end else if (cmd_wr && WDATA[actuator_cfg_pkg::CMD_READ]) begin
                  bus_addr_ff <= target_ff;
                  bus_rd_ff   <= 1'b1;
                  state_ff    <= S_READ;
               end else if (cmd_wr && WDATA[actuator_cfg_pkg::CMD_PERIOD]) begin
                  // High part first: period bits 14..7 form the high register.
                  bus_addr_ff  <= actuator_cfg_pkg::OFS_RESONANT_PERIOD_HIGH;
                  bus_wdata_ff <= wide_ff[14:7];
                  bus_wr_ff    <= 1'b1;
                  is_scale_ff  <= 1'b0;
                  state_ff     <= S_PAIR_HI;
               end else if (cmd_wr && WDATA[actuator_cfg_pkg::CMD_SCALE]) begin
                  bus_addr_ff  <= actuator_cfg_pkg::OFS_DRIVE_SCALE_HIGH;
                  bus_wdata_ff <= wide_ff[15:8];
                  bus_wr_ff    <= 1'b1;
                  is_scale_ff  <= 1'b1;
                  state_ff     <= S_PAIR_HI;
               end
            end
            S_PAIR_HI: begin
               // Low part: remainder after 128 times the high byte, or the low scale byte.
               bus_wr_ff <= 1'b1;
               if (is_scale_ff) begin
                  bus_addr_ff  <= actuator_cfg_pkg::OFS_DRIVE_SCALE_LOW;
                  bus_wdata_ff <= wide_ff[7:0];
               end else begin
                  bus_addr_ff  <= actuator_cfg_pkg::OFS_RESONANT_PERIOD_LOW;
                  bus_wdata_ff <= {1'b0, wide_ff[6:0]};
               end
               state_ff <= S_PAIR_LO;
            end
            S_READ: begin
               state_ff <= S_READ_WAIT;
            end
            default: begin
               state_ff <= S_IDLE;
            end
         endcase
      end
   end

   // Read capture and completion flag; completion wins over a clear in the same cycle.
   always_ff @(posedge CLK) begin
      if (RST) begin
         last_rdata_ff <= 8'h00;
         done_ff       <= 1'b0;
      end else begin
         if (state_ff == S_READ_WAIT) begin
            last_rdata_ff <= bus.rdata;
         end
         if (finish) begin
            done_ff <= 1'b1;
         end else if (WR && ADDR == actuator_cfg_pkg::OFS_CTL_STATUS
                      && WDATA[actuator_cfg_pkg::STA_DONE]) begin
            done_ff <= 1'b0;
         end
      end
   end

   // Software read port, answered the cycle after the strobe.
   always_ff @(posedge CLK) begin
      if (RST) begin
         rdata_ff <= 8'h00;
      end else if (RD) begin
         if (ADDR == actuator_cfg_pkg::OFS_CTL_TARGET) begin
            rdata_ff <= target_ff;
         end else if (ADDR == actuator_cfg_pkg::OFS_CTL_WDATA) begin
            rdata_ff <= wdata_ff;
         end else if (ADDR == actuator_cfg_pkg::OFS_CTL_RDATA) begin
            rdata_ff <= last_rdata_ff;
         end else if (ADDR == actuator_cfg_pkg::OFS_CTL_STATUS) begin
            rdata_ff <= {6'h00, done_ff, busy};
         end else if (ADDR == actuator_cfg_pkg::OFS_CTL_WIDE_LO) begin
            rdata_ff <= wide_ff[7:0];
         end else if (ADDR == actuator_cfg_pkg::OFS_CTL_WIDE_HI) begin
            rdata_ff <= wide_ff[15:8];
         end else begin
            rdata_ff <= 8'h00;
         end
      end
   end

   assign RDATA     = rdata_ff;
   assign bus.addr  = bus_addr_ff;
   assign bus.wdata = bus_wdata_ff;
   assign bus.wr    = bus_wr_ff;
   assign bus.rd    = bus_rd_ff;

endmodule : actuator_cfg_host

`default_nettype wire

/* test/actuator_cfg_monitor.sv */
`timescale 1ns/1ns
`default_nettype none

module actuator_cfg_monitor (
   // Clock and reset.
   input  wire logic       CLK,
   input  wire logic       RST,
   // Register link between the two ends.
   input  wire logic [7:0] addr,
   input  wire logic [7:0] wdata,
   input  wire logic       wr,
   input  wire logic       rd,
   input  wire logic [7:0] rdata
);
   default clocking @(posedge CLK); endclocking
   default disable iff (RST);

   // Shadow of the bytes at 0x09 to 0x0e as written over the link.
   // The scale bytes are left out: the drive loop may rewrite them unseen.
   logic [7:0] shadow_ff [0:5];
   always_ff @(posedge CLK) begin
      if (RST) begin
         shadow_ff[0] <= 8'h4a;
         shadow_ff[1] <= 8'h21;
         shadow_ff[2] <= 8'h4f;
         shadow_ff[3] <= 8'h5a;
         shadow_ff[4] <= 8'h78;
         shadow_ff[5] <= 8'h17;
      end else if (wr && addr >= 8'h09 && addr <= 8'h0e) begin
         shadow_ff[3'(addr - 8'h09)] <= wdata;
      end
   end

   a_base_readback: assert property (rd && addr == 8'h09 |=>
      rdata == {1'b0, shadow_ff[0][6:0]}) else $error("base address read back wrong");
   a_period_hi_read: assert property (rd && addr == 8'h0a |=>
      rdata == shadow_ff[1]) else $error("period high byte read back wrong");
   a_period_lo_read: assert property (rd && addr == 8'h0b |=>
      rdata == {1'b0, shadow_ff[2][6:0]}) else $error("period low bits read back wrong");
   a_nominal_read: assert property (rd && addr == 8'h0c |=>
      rdata == shadow_ff[3]) else $error("nominal rating read back wrong");
   a_absolute_read: assert property (rd && addr == 8'h0d |=>
      rdata == shadow_ff[4]) else $error("absolute rating read back wrong");
   a_current_code_read: assert property (rd && addr == 8'h0e |=>
      rdata == {3'h0, shadow_ff[5][4:0]}) else $error("current code read back wrong");
   a_imp_lo_upper: assert property (rd && addr == 8'h12 |=>
      rdata[7:2] == 6'h00) else $error("impedance low upper bits not zero");
   a_unmapped_zero: assert property (rd && addr > 8'h12 |=> rdata == 8'h00)
      else $error("unmapped read not zero");
   a_rdata_holds: assert property (!rd |=> $stable(rdata))
      else $error("read data moved without a read");
   a_strobes_apart: assert property (!(wr && rd))
      else $error("write and read strobes together");

   c_period_pair: cover property (wr && addr == 8'h0a ##1 wr && addr == 8'h0b);
   c_imp_read: cover property (rd && addr == 8'h11);
   c_unmapped: cover property (rd && addr > 8'h12);
endmodule : actuator_cfg_monitor

`default_nettype wire

/* test/tb_actuator_config_registers.sv */
`timescale 1ns/1ns
`default_nettype none

module tb_actuator_config_registers;
   // Clock, reset and software port.
   logic        clk;
   logic        rst;
   logic [7:0]  sw_addr;
   logic [7:0]  sw_wdata;
   logic        sw_wr;
   logic        sw_rd;
   logic [7:0]  sw_rdata;
   logic        want_check;
   logic        check_ff = 1'b0;
   // Drive loop side of the device.
   logic        accel_en;
   logic        freeze;
   logic        scale_upd;
   logic [15:0] scale_new;
   logic        imp_upd;
   logic [7:0]  imp_hi;
   logic [1:0]  imp_lo;
   logic [6:0]  base_addr;
   logic [14:0] period;
   logic [7:0]  full_scale;
   logic [7:0]  od_limit;
   logic        clamp_en;
   logic [4:0]  cur_code;
   logic [15:0] scale_val;
   // Bookkeeping and expectations.
   int          errors;
   int          total_checks;
   int          seed;
   logic [7:0]  expq [$];
   logic [7:0]  wv [0:7];
   logic [15:0] v;
   logic [7:0]  rv [0:9] = '{8'h4a, 8'h21, 8'h4f, 8'h5a, 8'h78, 8'h17, 8'h01, 8'h0d, 8'h00, 8'h00};
   logic [7:0]  mk [0:7] = '{8'h7f, 8'hff, 8'h7f, 8'hff, 8'hff, 8'h1f, 8'hff, 8'hff};

   actuator_cfg_if actuator_cfg_if_i ();
   actuator_cfg_host actuator_cfg_host_i (.CLK(clk), .RST(rst), .ADDR(sw_addr),
      .WDATA(sw_wdata), .WR(sw_wr), .RD(sw_rd), .RDATA(sw_rdata), .bus(actuator_cfg_if_i.host));
   actuator_config_registers actuator_config_registers_i (.CLK(clk), .RST(rst),
      .bus(actuator_cfg_if_i.device), .ACCEL_EN(accel_en), .SCALE_UPDATE_FREEZE(freeze),
      .SCALE_UPD(scale_upd), .SCALE_NEW(scale_new), .IMP_UPD(imp_upd), .IMP_HI_IN(imp_hi),
      .IMP_LO_IN(imp_lo), .BASE_ADDR(base_addr), .RESONANT_PERIOD_VALUE(period),
      .FULL_SCALE(full_scale), .OVERDRIVE_LIMIT(od_limit), .OVERDRIVE_CLAMP_EN(clamp_en),
      .CURRENT_LIMIT_CODE(cur_code), .DRIVE_SCALE_VALUE(scale_val));
   actuator_cfg_monitor actuator_cfg_monitor_i (.CLK(clk), .RST(rst),
      .addr(actuator_cfg_if_i.addr), .wdata(actuator_cfg_if_i.wdata), .wr(actuator_cfg_if_i.wr),
      .rd(actuator_cfg_if_i.rd), .rdata(actuator_cfg_if_i.rdata));

   // Free running bench clock.
   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end

   task automatic tally_and_finish();
      errors += expq.size();
      $display("checks %0d, errors %0d", total_checks, errors);
      if (errors == 0 && total_checks > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask : tally_and_finish

   task automatic chk(input logic [15:0] got, input logic [15:0] want);
      total_checks++;
      if (got !== want) begin
         errors++;
         $display("mismatch at %0t: got %h expected %h", $time, got, want);
      end
   endtask : chk

   // Each checked read answers one cycle later; the oldest note is compared then.
   always @(posedge clk) begin
      if (check_ff) begin
         if (expq.size() == 0) begin
            errors++;
            $display("mismatch at %0t: read answer with no expectation", $time);
         end else begin
            chk(sw_rdata, expq.pop_front());
         end
      end
      check_ff <= sw_rd && want_check;
   end

   task automatic sw_write(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      sw_addr  <= a;
      sw_wdata <= d;
      sw_wr    <= 1'b1;
      @(posedge clk);
      sw_wr    <= 1'b0;
   endtask : sw_write

   task automatic sw_read(input logic [7:0] a, input logic [7:0] e, input logic c);
      @(posedge clk);
      sw_addr    <= a;
      sw_rd      <= 1'b1;
      want_check <= c;
      if (c) expq.push_back(e);
      @(posedge clk);
      sw_rd      <= 1'b0;
      want_check <= 1'b0;
   endtask : sw_read

   // Polls the done flag a bounded number of times, then clears it.
   task automatic wait_done();
      int n;
      for (n = 0; n < 16; n++) begin
         sw_read(actuator_cfg_pkg::OFS_CTL_STATUS, 8'h00, 1'b0);
         #1;
         if (sw_rdata[actuator_cfg_pkg::STA_DONE] === 1'b1) break;
      end
      if (n == 16) begin
         errors++;
         $display("mismatch at %0t: command never finished", $time);
         tally_and_finish();
      end else begin
         sw_write(actuator_cfg_pkg::OFS_CTL_STATUS, 8'h02);
      end
   endtask : wait_done

   task automatic dev_write(input logic [7:0] o, input logic [7:0] d);
      sw_write(actuator_cfg_pkg::OFS_CTL_TARGET, o);
      sw_write(actuator_cfg_pkg::OFS_CTL_WDATA, d);
      sw_write(actuator_cfg_pkg::OFS_CTL_CMD, 8'h01);
      wait_done();
   endtask : dev_write

   task automatic dev_read(input logic [7:0] o, input logic [7:0] e);
      sw_write(actuator_cfg_pkg::OFS_CTL_TARGET, o);
      sw_write(actuator_cfg_pkg::OFS_CTL_CMD, 8'h02);
      wait_done();
      sw_read(actuator_cfg_pkg::OFS_CTL_RDATA, e, 1'b1);
   endtask : dev_read

   task automatic wide_write(input logic [7:0] cmd, input logic [15:0] w);
      sw_write(actuator_cfg_pkg::OFS_CTL_WIDE_LO, w[7:0]);
      sw_write(actuator_cfg_pkg::OFS_CTL_WIDE_HI, w[15:8]);
      sw_write(actuator_cfg_pkg::OFS_CTL_CMD, cmd);
      wait_done();
   endtask : wide_write

   // Main sequence; scale updates stay idle until the register pass is over.
   initial begin
      {rst, sw_wr, sw_rd, want_check, accel_en, freeze} = 6'h20;
      {scale_upd, imp_upd, sw_addr, sw_wdata, scale_new, imp_hi, imp_lo} = '0;
      errors = 0;
      total_checks = 0;
      seed = 32'h6c79;
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      for (int i = 0; i < 10; i++) dev_read(8'h09 + 8'(i), rv[i]);
      for (int i = 0; i < 8; i++) begin
         wv[i] = 8'($random(seed));
         dev_write(8'h09 + 8'(i), wv[i]);
         wv[i] = wv[i] & mk[i];
      end
      for (int i = 0; i < 8; i++) dev_read(8'h09 + 8'(i), wv[i]);
      chk(base_addr, wv[0][6:0]);
      chk(period, {wv[1], wv[2][6:0]});
      chk(cur_code, wv[5][4:0]);
      chk(scale_val, {wv[6], wv[7]});
      dev_write(8'h11, 8'hff);
      dev_write(8'h12, 8'hff);
      dev_read(8'h11, 8'h00);
      dev_read(8'h12, 8'h00);
      @(posedge clk) accel_en <= 1'b1;
      repeat (2) @(posedge clk);
      #1;
      chk(full_scale, wv[3]);
      chk(od_limit, wv[4]);
      chk(clamp_en, 1'b1);
      @(posedge clk) accel_en <= 1'b0;
      repeat (2) @(posedge clk);
      #1;
      chk(full_scale, wv[4]);
      chk(clamp_en, 1'b0);
      v = 16'($random(seed)) & 16'h7fff;
      wide_write(8'h04, v);
      chk(period, v[14:0]);
      dev_read(8'h0a, v[14:7]);
      dev_read(8'h0b, {1'b0, v[6:0]});
      v = 16'($random(seed));
      wide_write(8'h08, v);
      chk(scale_val, v);
      dev_read(8'h0f, v[15:8]);
      dev_read(8'h10, v[7:0]);
      sw_read(actuator_cfg_pkg::OFS_CTL_WIDE_LO, v[7:0], 1'b1);
      // A frozen update must leave the scale alone, a free one must load it.
      @(posedge clk);
      freeze    <= 1'b1;
      scale_new <= ~v;
      scale_upd <= 1'b1;
      @(posedge clk) scale_upd <= 1'b0;
      @(posedge clk);
      #1;
      chk(scale_val, v);
      @(posedge clk);
      freeze    <= 1'b0;
      scale_upd <= 1'b1;
      @(posedge clk) scale_upd <= 1'b0;
      @(posedge clk);
      #1;
      chk(scale_val, ~v);
      dev_read(8'h0f, ~v[15:8]);
      @(posedge clk);
      imp_hi  <= 8'($random(seed));
      imp_lo  <= 2'($random(seed));
      imp_upd <= 1'b1;
      @(posedge clk) imp_upd <= 1'b0;
      dev_read(8'h11, imp_hi);
      dev_read(8'h12, {6'h00, imp_lo});
      dev_read(8'h30, 8'h00);
      sw_read(8'h40, 8'h00, 1'b1);
      // A second reset in mid-run must restore the documented values.
      @(posedge clk) rst <= 1'b1;
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      dev_read(8'h09, 8'h4a);
      dev_read(8'h0a, 8'h21);
      chk(base_addr, 7'h4a);
      repeat (3) @(posedge clk);
      tally_and_finish();
   end
endmodule : tb_actuator_config_registers

`default_nettype wire
